// ---- hdl/serial_port_regs.svh ----
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH

// ****************************************
// Timing of the internal shift clock
// ****************************************
`define CLK_PERIOD_PS 5000
`define SCLK_QUARTER_NS 20
`define SCLK_QUARTER_CYC ((`SCLK_QUARTER_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

// ****************************************
// Pin positions on the parallel bus, result width, FIFO depth and reset value
// ****************************************
`define PIN_CHAIN_POS 7
`define PIN_SDO_POS 8
`define PIN_SCLK_POS 9
`define PIN_B10_POS 10
`define RESULT_BITS 16
`define FIFO_DEPTH 16
`define RESULT_RESET 16'h0000

`endif

// ---- hdl/serial_port_pkg.sv ----
package serial_port_pkg;

    // Pin-level controls, after synchronisation
    typedef struct packed {
        logic port_select;
        logic output_coding_select;
        logic clock_source_select;
        logic shift_clock_invert;
        logic read_mode_or_chain_in;
        logic sclk_in;
    } cfg_type;

    typedef enum logic [1:0] {
        IDLE = 2'b00,
        INT_SHIFT = 2'b01,
        EXT_SHIFT = 2'b10,
        DONE = 2'b11
    } state_type;

endpackage : serial_port_pkg

// ---- hdl/adc_serial_result_port.sv ----
// Notes on behaviour
// - Port select low: pin 7 drives result bit 7; high: it is an input.
// - External clock: chain input appears on serial out 16 shift periods later.
// - Internal clock, read mode high: shifting may run during a conversion.
// - Internal clock, read mode low: shifting waits for conversion end.
// - Result leaves the shift register most significant bit first.
// - Serial coding follows the output coding select pin.
// - Internal clock: each bit stable across both shift clock edges.
// - External clock, no invert: update on rising edge, valid at falling.
// - External clock, invert: update on falling edge, valid at rising.
// - Pin 9 is shift clock, in or out by source, edge by invert.
// - Pin 8 becomes serial data output in serial mode.
// - Parallel mode: bit 10 driven on its own pin.
// - Coding select high: straight binary; low: MSB inverted.
// - Source low: internal clock driven out; high: external clock used.
// - Invert input flips clock sense in both serial modes.
`timescale 1ns/100ps
`include "serial_port_regs.svh"

// ****************************************
// Result FIFO
// ****************************************
module result_fifo #(
    parameter int WIDTH = `RESULT_BITS,
    parameter int DEPTH = `FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_r;
    logic [AW:0] rd_r;

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("result_fifo: DEPTH must be a power of two");
        end
    end

    assign in_ready = (wr_r[AW] == rd_r[AW]) || (wr_r[AW-1:0] != rd_r[AW-1:0]);
    assign out_valid = wr_r != rd_r;
    assign out_data = mem[rd_r[AW-1:0]];

    always_ff @(posedge clk) begin
        if (in_valid && in_ready) begin
            mem[wr_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            if (in_valid && in_ready) begin
                wr_r <= wr_r + 1'b1;
            end
            if (out_valid && out_ready) begin
                rd_r <= rd_r + 1'b1;
            end
        end
    end
endmodule : result_fifo

// ****************************************
// Serial and parallel result port
// ****************************************
module adc_serial_result_port #(
    parameter int QUARTER_CYC = `SCLK_QUARTER_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Results from the converter core
    input wire logic result_valid,
    output logic result_ready,
    input wire logic [`RESULT_BITS-1:0] result_data,
    input wire logic conv_busy,
    input wire logic read_enable,
    // Mode pins, outside the clock domain
    input wire logic port_select,
    input wire logic output_coding_select,
    input wire logic clock_source_select,
    input wire logic shift_clock_invert,
    // Pin 7: result bit 7 or read mode / chain input
    input wire logic pin7_in,
    output logic pin7_out,
    output logic pin7_oe_n,
    // Pin 8: result bit 8 or serial data out
    output logic pin8_out,
    // Pin 9: result bit 9 or shift clock
    input wire logic pin9_in,
    output logic pin9_out,
    output logic pin9_oe_n,
    // Pin 10: result bit 10
    output logic pin10_out,
    // Status
    output logic serial_busy
);
    import serial_port_pkg::*;

    initial begin
        if (QUARTER_CYC < 1 || QUARTER_CYC > 255) begin
            $error("adc_serial_result_port: QUARTER_CYC out of range");
        end
    end

    function automatic logic [`RESULT_BITS-1:0] code_result(
        input logic [`RESULT_BITS-1:0] raw,
        input logic straight
    );
        code_result = raw;
        code_result[`RESULT_BITS-1] = raw[`RESULT_BITS-1] ^ ~straight;
    endfunction : code_result

    // ****************************************
    // Input synchronisers
    // ****************************************
    localparam int NS = $bits(cfg_type);
    logic [NS-1:0] raw_w;
    logic [NS-1:0] s1_r;
    logic [NS-1:0] s2_r;
    logic [NS-1:0] s3_r;
    logic [NS-1:0] stable_r;
    cfg_type cfg;
    logic sclk_prev_r;

    assign raw_w = {port_select, output_coding_select, clock_source_select,
                    shift_clock_invert, pin7_in, pin9_in};
    assign cfg = cfg_type'(stable_r);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= raw_w;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A change counts only once two stages agree
    for (genvar i = 0; i < NS; i++) begin : g_stable
        always_ff @(posedge clk) begin
            if (!resetn) begin
                stable_r[i] <= 1'b0;
            end else if (s2_r[i] == s3_r[i]) begin
                stable_r[i] <= s3_r[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sclk_prev_r <= 1'b0;
        end else begin
            sclk_prev_r <= cfg.sclk_in;
        end
    end

    logic upd_edge;
    assign upd_edge = (cfg.sclk_in != sclk_prev_r) && (cfg.sclk_in == ~cfg.shift_clock_invert);

    // ****************************************
    // Result buffer and parallel word
    // ****************************************
    logic fifo_valid;
    logic pop_w;
    logic [`RESULT_BITS-1:0] fifo_data;
    logic [`RESULT_BITS-1:0] res_r;

    result_fifo #(.WIDTH(`RESULT_BITS), .DEPTH(`FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .in_valid(result_valid),
        .in_ready(result_ready),
        .in_data(result_data),
        .out_valid(fifo_valid),
        .out_ready(pop_w),
        .out_data(fifo_data)
    );

    // ****************************************
    // Serial engine
    // ****************************************
    state_type state_r;
    state_type state_nxt;
    logic rd_prev_r;
    logic start_w;
    logic load_w;
    logic [`RESULT_BITS-1:0] shift_r;
    logic [7:0] pre_r;
    logic [1:0] phase_r;
    logic [4:0] bit_r;
    logic tick_w;
    logic int_ok;

    assign start_w = read_enable && !rd_prev_r;
    assign int_ok = cfg.read_mode_or_chain_in || !conv_busy;
    assign load_w = (state_r == IDLE) && cfg.port_select && start_w &&
                    (cfg.clock_source_select || int_ok);
    assign pop_w = fifo_valid && (cfg.port_select ? load_w : 1'b1);
    assign tick_w = pre_r == 8'(QUARTER_CYC - 1);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rd_prev_r <= 1'b0;
        end else if (state_r != IDLE || !start_w || load_w) begin
            rd_prev_r <= read_enable;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            res_r <= `RESULT_RESET;
        end else if (pop_w) begin
            res_r <= fifo_data;
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            IDLE: begin
                if (load_w) begin
                    state_nxt = cfg.clock_source_select ? EXT_SHIFT : INT_SHIFT;
                end
            end
            INT_SHIFT: begin
                if (tick_w && phase_r == 2'b11 && bit_r == 5'(`RESULT_BITS - 1)) begin
                    state_nxt = DONE;
                end
            end
            EXT_SHIFT: begin
                if (!read_enable) begin
                    state_nxt = IDLE;
                end
            end
            DONE: begin
                if (!read_enable) begin
                    state_nxt = IDLE;
                end
            end
            default: begin
                state_nxt = IDLE;
            end
        endcase
        if (!cfg.port_select) begin
            state_nxt = IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r <= IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Quarter-period prescaler; phase 0 holds the data change
    always_ff @(posedge clk) begin
        if (!resetn || state_r != INT_SHIFT) begin
            pre_r <= 8'h00;
            phase_r <= 2'b00;
            bit_r <= 5'h00;
        end else if (tick_w) begin
            pre_r <= 8'h00;
            phase_r <= phase_r + 2'b01;
            if (phase_r == 2'b11) begin
                bit_r <= bit_r + 5'h01;
            end
        end else begin
            pre_r <= pre_r + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            shift_r <= `RESULT_RESET;
        end else if (load_w) begin
            shift_r <= code_result(fifo_valid ? fifo_data : res_r, cfg.output_coding_select);
        end else if (state_r == INT_SHIFT && tick_w && phase_r == 2'b11) begin
            shift_r <= {shift_r[`RESULT_BITS-2:0], 1'b0};
        end else if (state_r == EXT_SHIFT && upd_edge) begin
            // chain bit enters at the bottom
            shift_r <= {shift_r[`RESULT_BITS-2:0], cfg.read_mode_or_chain_in};
        end
    end

    // ****************************************
    // Pins
    // ****************************************
    logic [`RESULT_BITS-1:0] par_w;
    logic sclk_int;

    assign par_w = code_result(res_r, cfg.output_coding_select);
    // edges fall in phases 1 and 3, data changes at phase 0
    assign sclk_int = cfg.shift_clock_invert ^ (state_r == INT_SHIFT && ^phase_r);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pin7_out <= 1'b0;
            pin8_out <= 1'b0;
            pin9_out <= 1'b0;
            pin10_out <= 1'b0;
        end else begin
            pin7_out <= par_w[`PIN_CHAIN_POS];
            pin8_out <= cfg.port_select ? shift_r[`RESULT_BITS-1] : par_w[`PIN_SDO_POS];
            pin9_out <= cfg.port_select ? sclk_int : par_w[`PIN_SCLK_POS];
            pin10_out <= par_w[`PIN_B10_POS];
        end
    end

    // pin 7 turns input in serial mode
    assign pin7_oe_n = cfg.port_select;
    // pin 9 is an input with an external clock
    assign pin9_oe_n = cfg.port_select && cfg.clock_source_select;
    assign serial_busy = state_r == INT_SHIFT || state_r == EXT_SHIFT;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_int_start;
        load_w && !cfg.clock_source_select;
    endsequence

    sequence s_bit_end;
        state_r == INT_SHIFT && tick_w && phase_r == 2'b11;
    endsequence

    a_pin7_input: assert property (cfg.port_select |-> pin7_oe_n)
        else $error("pin 7 driven in serial mode");
    // A pop moves the word under the pin, so only quiet cycles are compared
    a_pin7_bit: assert property (!cfg.port_select && !pop_w |=> pin7_out == par_w[7])
        else $error("pin 7 not showing bit 7");
    a_chain_in: assert property (
        state_r == EXT_SHIFT && upd_edge && !load_w
        |=> shift_r[0] == $past(cfg.read_mode_or_chain_in))
        else $error("chain bit not shifted in");
    a_wait_conv: assert property (
        state_r == IDLE && start_w && cfg.port_select && !cfg.clock_source_select
        && !cfg.read_mode_or_chain_in && conv_busy |=> state_r == IDLE)
        else $error("read started during conversion");
    a_read_conv: assert property (
        s_int_start and (conv_busy && cfg.read_mode_or_chain_in) |=> state_r == INT_SHIFT)
        else $error("read during conversion refused");
    a_msb_first: assert property (
        s_bit_end and (state_nxt == INT_SHIFT) |=> shift_r[15] == $past(shift_r[14]))
        else $error("shift not MSB first");
    a_msb_coding: assert property (
        load_w && !cfg.output_coding_select && !fifo_valid
        |=> shift_r[15] == !$past(res_r[15]))
        else $error("two's complement MSB not inverted");
    a_int_stable: assert property (
        state_r == INT_SHIFT && $changed(sclk_int) |-> $stable(shift_r))
        else $error("data moved at a clock edge");
    a_ext_hold: assert property (
        state_r == EXT_SHIFT && !upd_edge && state_nxt == EXT_SHIFT |=> $stable(shift_r))
        else $error("data moved off the update edge");
    a_sclk_pin: assert property (cfg.port_select && !cfg.clock_source_select |-> !pin9_oe_n)
        else $error("internal clock not driven");
endmodule : adc_serial_result_port

// ---- dv/host_model.sv ----
`timescale 1ns/100ps
// ****************************************
// Host reading with its own shift clock
// ****************************************
module host_model (
    // Serial data from the port
    input wire logic sdo,
    // Shift clock and upstream chain data
    output logic sclk,
    output logic chain
);
    logic invert;
    logic [31:0] got;
    logic [15:0] up;
    int bad;
    initial begin
        invert = 1'b0;
        sclk = 1'b1;
        chain = 1'b0;
        got = 32'h0000_0000;
        up = 16'h0000;
        bad = 0;
    end
    // Clock parks at the update level, so the first edge of a frame samples the MSB
    task automatic park(input logic inv, input logic [15:0] word);
        invert = inv;
        sclk = ~inv;
        up = word;
        chain = word[15];
    endtask : park
    task automatic shift(input int n);
        #7.3;
        for (int i = 0; i < n; i++) begin
            sclk = invert;
            got = {got[30:0], sdo};
            // Data must stand until the next update edge, not move on ours
            #60;
            if (sdo !== got[0]) begin
                bad++;
            end
            #20;
            sclk = ~invert;
            #30;
            up = {up[14:0], ~up[15]};
            chain = up[15];
            #50;
        end
    endtask : shift
endmodule : host_model

// ---- dv/adc_serial_result_port_test.sv ----
`timescale 1ns/100ps
module adc_serial_result_port_test;
    logic clk;
    logic resetn;
    logic result_valid;
    logic result_ready;
    logic [15:0] result_data;
    logic conv_busy;
    logic read_enable;
    logic port_select;
    logic output_coding_select;
    logic clock_source_select;
    logic shift_clock_invert;
    logic read_mode;
    logic pin7_wire;
    logic pin7_out;
    logic pin7_oe_n;
    logic pin8_out;
    logic pin9_wire;
    logic pin9_out;
    logic pin9_oe_n;
    logic pin10_out;
    logic serial_busy;
    logic host_sclk;
    logic host_chain;
    logic [15:0] w;
    int error_cnt;
    int check_count;

    // Two-way pins resolve from the port's output enables; clock_source_select picks pin 7's outside driver
    assign pin7_wire = pin7_oe_n ? (clock_source_select ? host_chain : read_mode) : pin7_out;
    assign pin9_wire = pin9_oe_n ? host_sclk : pin9_out;

    adc_serial_result_port #(.QUARTER_CYC(1)) adc_serial_result_port_inst (
        .clk(clk), .resetn(resetn), .result_valid(result_valid),
        .result_ready(result_ready), .result_data(result_data), .conv_busy(conv_busy),
        .read_enable(read_enable), .port_select(port_select),
        .output_coding_select(output_coding_select),
        .clock_source_select(clock_source_select), .shift_clock_invert(shift_clock_invert),
        .pin7_in(pin7_wire), .pin7_out(pin7_out), .pin7_oe_n(pin7_oe_n),
        .pin8_out(pin8_out), .pin9_in(pin9_wire), .pin9_out(pin9_out),
        .pin9_oe_n(pin9_oe_n), .pin10_out(pin10_out), .serial_busy(serial_busy)
    );
    host_model host_model_inst (.sdo(pin8_out), .sclk(host_sclk), .chain(host_chain));

    always #2.5 clk = ~clk;

    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic conclude;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    // ****************************************
    // Access tasks
    // ****************************************
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle
    function automatic logic [15:0] coded(input logic [15:0] v, input logic ocs);
        return {v[15] ^ ~ocs, v[14:0]};
    endfunction : coded
    task automatic push(input logic [15:0] v, input logic ok);
        @(negedge clk);
        check("room", result_ready, ok);
        result_valid = 1'b1;
        result_data = v;
        @(negedge clk);
        result_valid = 1'b0;
    endtask : push
    // Internal clock read; samples on the leading edge, rechecks on the trailing one
    task automatic int_read(input logic [15:0] exp, input logic wait_busy);
        logic [15:0] got;
        logic lvl;
        logic bitv;
        int n;
        int t;
        got = 16'h0000;
        bitv = 1'b0;
        n = 0;
        t = 0;
        read_enable = 1'b1;
        if (wait_busy) begin
            idle(20);
            check("held", serial_busy, 1'b0);
            conv_busy = 1'b0;
        end
        lvl = shift_clock_invert;
        while (n < 16 && t < 2000) begin
            @(negedge clk);
            t++;
            if (pin9_out !== lvl) begin
                lvl = pin9_out;
                if (lvl !== shift_clock_invert) begin
                    got = {got[14:0], pin8_out};
                    bitv = pin8_out;
                end else begin
                    check("both edges", pin8_out, bitv);
                    if (n == 0) check("int oe", {pin7_oe_n, pin9_oe_n, serial_busy}, 3'b101);
                    n++;
                end
            end
        end
        check("int bits", n, 16);
        check("int word", got, exp);
        conv_busy = 1'b0;
        read_enable = 1'b0;
        idle(6);
    endtask : int_read

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        result_valid = 1'b0;
        result_data = 16'h0000;
        conv_busy = 1'b0;
        read_enable = 1'b0;
        port_select = 1'b0;
        output_coding_select = 1'b1;
        clock_source_select = 1'b0;
        shift_clock_invert = 1'b0;
        read_mode = 1'b0;
        error_cnt = 0;
        check_count = 0;
        idle(16);
        resetn = 1'b1;
        idle(8);
        for (int i = 0; i < 2; i++) begin
            w = i ? 16'h5A5A : 16'hA5A5;
            push(w, 1'b1);
            idle(4);
            check("par pins", {pin10_out, pin9_out, pin8_out, pin7_out}, w[10:7]);
            check("par oe", {pin7_oe_n, pin9_oe_n}, 2'b00);
        end
        // Serial mode drains one word per read, so the queue fills up
        port_select = 1'b1;
        idle(8);
        for (int i = 0; i < 16; i++) push(16'h8C35 ^ (i[15:0] * 16'h1357), 1'b1);
        push(16'hFFFF, 1'b0);
        for (int i = 0; i < 16; i++) begin
            w = 16'h8C35 ^ (i[15:0] * 16'h1357);
            output_coding_select = i[1];
            shift_clock_invert = i[0];
            read_mode = (i != 0);
            conv_busy = (i < 2);
            idle(8);
            int_read(coded(w, i[1]), i == 0);
        end
        check("drained", result_ready, 1'b1);
        // Empty queue: the read repeats the last result, recoded at load
        output_coding_select = 1'b0;
        idle(8);
        int_read(coded(w, 1'b0), 1'b0);
        clock_source_select = 1'b1;
        output_coding_select = 1'b1;
        for (int i = 0; i < 2; i++) begin
            w = 16'hC3A5 ^ i[15:0];
            shift_clock_invert = i[0];
            host_model_inst.park(i[0], 16'h3C96);
            push(w, 1'b1);
            idle(8);
            read_enable = 1'b1;
            idle(8);
            check("ext oe", {pin7_oe_n, pin9_oe_n}, 2'b11);
            host_model_inst.shift(32);
            idle(1);
            check("ext word", host_model_inst.got[31:16], w);
            check("ext stable", host_model_inst.bad, 0);
            check("chain", host_model_inst.got[15:0], 16'h3C96);
            read_enable = 1'b0;
            idle(8);
        end
        conclude();
    end

    initial begin
        repeat (100000) @(posedge clk);
        check("watchdog", 1'b1, 1'b0);
        conclude();
    end
endmodule : adc_serial_result_port_test
